// ==== pkg/acl_pkg.sv ====
// Shared constants and types for the converter readback and CRC link
package acl_pkg;
  // Frame bytes and command opcodes
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [7:0] OP_READ_DATA = 8'h12;
  localparam logic [2:0] OP_READ_REG_HI = 3'h1;
  localparam logic [4:0] STATUS_REG_ADDR = 5'h01;
  localparam logic [3:0] CMD_BYTES = 4'h4;
  // CRC
  localparam logic [8:0] CRC_POLY = 9'h107;
  localparam int CRC_ARG_W = 40;
  // Result codes
  localparam logic [23:0] CODE_POS_MAX = 24'h7FFFFF;
  localparam logic [23:0] CODE_NEG_MIN = 24'h800000;
  // Status byte fields and reset value
  localparam int STAT_READY_BIT = 6;
  localparam int STAT_CONV_CRC_BIT = 5;
  localparam int STAT_GAIN_SUM_BIT = 4;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Ready pulse lead, in master clock cycles
  localparam logic [23:0] LEAD_CYCLES = 24'h000010;

  // Snapshot handed to the link for one readback
  typedef struct packed {
    logic append;
    logic [7:0] status;
    logic [23:0] data;
  } acl_hold_t;

  // Command taken from a good frame
  typedef struct packed {
    logic gain;
    logic [7:0] op;
    logic [7:0] arg;
  } acl_cmd_t;
endpackage

// ==== src/acl_sync.sv ====
// Two flip-flop level synchroniser
`timescale 1ns/1ns
module acl_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } acl_sync_t;

  acl_sync_t q, d;

  always_comb begin
    d = q;
    d.s1 = async_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.s2;
endmodule

// ==== src/acl_crc8.sv ====
// CRC-8 over a left-aligned argument of one to four bytes
`timescale 1ns/1ns
module acl_crc8 (
  // Argument, top byte first, unused bytes ignored
  input wire logic [31:0] arg,
  input wire logic [2:0] nbytes,
  // Remainder
  output logic [7:0] crc
);
  import acl_pkg::*;

  always_comb begin
    logic [CRC_ARG_W-1:0] v;
    v = {arg, FILL_BYTE};
    // Bytes past the argument are padded with ones
    for (int i = 0; i < 4; i++) begin
      if (i >= int'(nbytes)) begin
        v[CRC_ARG_W-1-8*i -: 8] = FILL_BYTE;
      end
    end
    // Reduce until nothing is left above the 8-bit remainder
    for (int i = CRC_ARG_W - 1; i >= 8; i--) begin
      if (v[i]) begin
        v[i -: 9] = v[i -: 9] ^ CRC_POLY;
      end
    end
    crc = v[7:0];
  end
endmodule

// ==== src/acl_link.sv ====
// Conversion-ready signalling, readback framing and command CRC link
// Operation
// - Continuous mode: ready output high at conversion start, low at new data.
// - Continuous mode: ready output held high while conversion data are read back.
// - Unread result: ready pulses high 16 cycles before the next falling edge.
// - Late read of old data delays the fall; status ready bit reads 0.
// - Late read of new data: normal fall, status ready bit reads 1.
// - Pulse mode: high at start, low at data, low until next start.
// - Status ready bit is 1 only for data new since last read.
// - Payload: optional status, three result bytes, CRC over them all.
// - Status prepended only when enabled; also readable by register read.
// - Results are 24-bit two's complement, sign bit first.
// - Zero is 000000h; overdrive clips to 7FFFFFh and 800000h.
// - Device checks command CRC, executes on match, returns CRC in byte four.
// - Good reads append 1, 3 or 4 payload bytes plus their CRC.
// - Mismatch: no execution, inverted computed CRC in byte four.
// - New command accepted after failed frame byte four or full good frame.
// - Converter CRC error sets its flag; gain error sets flag and summary.
// - CRC is remainder of division by x^8+x^2+x+1.
// - Argument left-aligned in 40 bits, padded with ones on the right.
// - Frame bytes two and three echo received bytes one and two.
// - Mode 1 link: clock idles low, change on rise, sample on fall.
// - Pin shows ready only with converter select low; floats with both high.
// - First byte shifted out of every frame is FFh.
`timescale 1ns/1ns
module acl_link #(
  parameter int RAW_W = 28
) (
  // Master clock domain
  input wire logic clk,
  input wire logic reset,
  // Conversion control and result from the modulator side
  input wire logic conv_start,
  input wire logic conv_stop,
  input wire logic continuous_mode,
  input wire logic [23:0] data_period,
  input wire logic signed [RAW_W-1:0] conv_raw,
  // Configuration and status
  input wire logic status_append_enable,
  input wire logic clear_crc_flags,
  output logic conv_ready_n,
  output logic converter_crc_error_flag,
  output logic gain_stage_crc_error_flag,
  output logic gain_stage_summary_flag,
  output logic [7:0] conversion_status_byte,
  output logic [23:0] conv_result,
  // Commands taken from good frames
  output logic cmd_valid,
  output acl_pkg::acl_cmd_t cmd,
  // Serial link, clocked by its own shift clock
  input wire logic sclk,
  input wire logic converter_select_n,
  input wire logic gain_stage_select_n,
  input wire logic serial_in,
  output logic serial_out_ready_pin_out,
  output logic serial_out_ready_pin_oe
);
  import acl_pkg::*;

  typedef struct packed {
    logic ready_n;
    logic new_flag;
    logic lead_seen;
    logic pending;
    logic running;
    logic [23:0] tmr;
    logic [23:0] res;
    acl_hold_t hold;
    logic [2:0] tgl_d;
    logic conv_err;
    logic gain_err;
    logic gain_sum;
    logic cmd_valid;
    acl_cmd_t cmd;
  } acl_sys_t;

  typedef struct packed {
    logic [2:0] bits;
    logic [3:0] bytes;
    logic [7:0] sh;
    logic [7:0] b1;
    logic [7:0] b2;
    logic gain;
    logic ok;
    logic busy;
    logic done;
    logic rd_reg;
    logic cmd_evt;
    logic err_evt;
    logic err_gain;
  } acl_lnk_t;

  typedef struct packed {
    logic active;
    logic dout;
  } acl_tx_t;

  acl_sys_t s_q, s_d;
  acl_lnk_t l_q, l_d;
  acl_tx_t t_q, t_d;
  acl_cmd_t cmd_keep_q, cmd_keep_d;

  logic frame_idle;
  logic [2:0] tgl_s;
  logic busy_s;
  logic busy_rise;
  logic cmd_edge;
  logic err_edge;
  logic conv_done;
  logic lead_hit;
  logic [23:0] sat;
  logic [7:0] ccrc;
  logic [7:0] pcrc;
  logic [31:0] payload;
  logic [2:0] plen;
  logic [3:0] pidx;
  logic [7:0] out_byte;
  logic [7:0] status_now;
  logic [7:0] rx_byte;
  logic is_read;

  // Link state is cleared by the select pins so a partial frame is dropped
  assign frame_idle = converter_select_n & gain_stage_select_n;

  // ---------------- Crossing into the master clock domain ----------------
  // Each level is set once per frame and cleared with the selects or, for busy, at payload end, so
  // only its rise is an event. A level set at the last bit stands only
  // until the select rises: the host holds the select one clock longer.
  acl_sync #(.W(3)) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in({l_q.busy, l_q.cmd_evt, l_q.err_evt}),
    .sync_out(tgl_s)
  );

  assign busy_s = tgl_s[2];
  assign busy_rise = tgl_s[2] & ~s_q.tgl_d[2];
  assign cmd_edge = tgl_s[1] & ~s_q.tgl_d[1];
  assign err_edge = tgl_s[0] & ~s_q.tgl_d[0];

  // ---------------- Master clock domain ----------------
  assign conv_done = s_q.running && (s_q.tmr == data_period - 24'h000001);
  assign lead_hit = s_q.running && continuous_mode &&
    (s_q.tmr == data_period - LEAD_CYCLES - 24'h000001);

  // Clip overdrive into the 24-bit code range
  assign sat = (&conv_raw[RAW_W-1:23] || ~|conv_raw[RAW_W-1:23]) ?
    conv_raw[23:0] : (conv_raw[RAW_W-1] ? CODE_NEG_MIN : CODE_POS_MAX);

  always_comb begin
    status_now = STATUS_RESET;
    status_now[STAT_READY_BIT] = s_q.new_flag;
    status_now[STAT_CONV_CRC_BIT] = s_q.conv_err;
    status_now[STAT_GAIN_SUM_BIT] = s_q.gain_sum;
  end

  always_comb begin
    s_d = s_q;
    s_d.tgl_d = tgl_s;
    s_d.cmd_valid = 1'b0;
    if (s_q.running) begin
      s_d.tmr = s_q.tmr + 24'h000001;
    end
    if (lead_hit) begin
      s_d.ready_n = 1'b1;
      s_d.lead_seen = 1'b1;
    end
    if (conv_done) begin
      s_d.tmr = '0;
      s_d.res = sat;
      s_d.running = continuous_mode;
      if (busy_s) begin
        s_d.pending = 1'b1;
      end else begin
        s_d.ready_n = 1'b0;
        s_d.new_flag = 1'b1;
        s_d.lead_seen = 1'b0;
      end
    end
    // Deferred fall once the read of the old result has finished
    if (s_q.pending && !busy_s) begin
      s_d.pending = 1'b0;
      s_d.ready_n = 1'b0;
      s_d.new_flag = 1'b1;
      s_d.lead_seen = 1'b0;
    end
    // A read takes a stable snapshot; late reads see the previous result
    if (busy_rise) begin
      s_d.hold.append = status_append_enable;
      s_d.hold.status = status_now;
      s_d.hold.status[STAT_READY_BIT] = s_q.new_flag & ~s_q.lead_seen;
      s_d.hold.data = s_q.res;
      s_d.new_flag = 1'b0;
      if (continuous_mode) begin
        s_d.ready_n = 1'b1;
      end
    end
    if (conv_start) begin
      s_d.running = 1'b1;
      s_d.tmr = '0;
      s_d.ready_n = 1'b1;
      s_d.lead_seen = 1'b0;
      s_d.pending = 1'b0;
    end else if (conv_stop) begin
      s_d.running = 1'b0;
    end
    if (cmd_edge) begin
      s_d.cmd_valid = 1'b1;
      s_d.cmd = cmd_keep_q;
    end
    // Clearing loses to a same-cycle error
    if (clear_crc_flags) begin
      s_d.conv_err = 1'b0;
      s_d.gain_err = 1'b0;
      s_d.gain_sum = 1'b0;
    end
    if (err_edge) begin
      if (l_q.err_gain) begin
        s_d.gain_err = 1'b1;
        s_d.gain_sum = 1'b1;
      end else begin
        s_d.conv_err = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.ready_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign conv_ready_n = s_q.ready_n;
  assign converter_crc_error_flag = s_q.conv_err;
  assign gain_stage_crc_error_flag = s_q.gain_err;
  assign gain_stage_summary_flag = s_q.gain_sum;
  assign conversion_status_byte = status_now;
  assign conv_result = s_q.res;
  assign cmd_valid = s_q.cmd_valid;
  assign cmd = s_q.cmd;

  // ---------------- Link clock domain ----------------
  acl_crc8 u_cmd_crc (
    .arg({l_q.b1, l_q.b2, 16'h0000}),
    .nbytes(3'h2),
    .crc(ccrc)
  );

  // Snapshot is stable from a few master clocks after busy rises
  always_comb begin
    if (l_q.rd_reg) begin
      payload = {s_q.hold.status, 24'h000000};
      plen = 3'h1;
    end else if (s_q.hold.append) begin
      payload = {s_q.hold.status, s_q.hold.data};
      plen = 3'h4;
    end else begin
      payload = {s_q.hold.data, 8'h00};
      plen = 3'h3;
    end
  end

  acl_crc8 u_pay_crc (
    .arg(payload),
    .nbytes(plen),
    .crc(pcrc)
  );

  assign pidx = l_q.bytes - CMD_BYTES;

  always_comb begin
    unique case (l_q.bytes)
      4'h0: out_byte = FILL_BYTE;
      4'h1: out_byte = l_q.b1;
      4'h2: out_byte = l_q.b2;
      4'h3: out_byte = l_q.ok ? ccrc : ~ccrc;
      default: begin
        if (!l_q.busy) begin
          out_byte = FILL_BYTE;
        end else if (pidx < {1'b0, plen}) begin
          out_byte = payload[31 - 8 * pidx -: 8];
        end else begin
          out_byte = pcrc;
        end
      end
    endcase
  end

  assign rx_byte = {l_q.sh[6:0], serial_in};
  assign is_read = (l_q.b1 == OP_READ_DATA && !l_q.gain) ||
    (l_q.b1 == {OP_READ_REG_HI, STATUS_REG_ADDR});

  always_comb begin
    l_d = l_q;
    cmd_keep_d = cmd_keep_q;
    l_d.sh = rx_byte;
    l_d.bits = l_q.bits + 3'h1;
    l_d.gain = ~gain_stage_select_n;
    if (l_q.bits == 3'h7 && !l_q.done) begin
      l_d.bytes = l_q.bytes + 4'h1;
      unique case (l_q.bytes)
        4'h0: l_d.b1 = rx_byte;
        4'h1: l_d.b2 = rx_byte;
        4'h2: begin
          l_d.ok = (rx_byte == ccrc);
          if (rx_byte == ccrc) begin
            l_d.busy = is_read;
            l_d.rd_reg = (l_q.b1 != OP_READ_DATA);
          end else begin
            l_d.err_evt = 1'b1;
            l_d.err_gain = l_q.gain;
          end
        end
        4'h3: begin
          // Execution starts at the last clock of the fourth byte
          if (l_q.ok) begin
            cmd_keep_d = '{gain: l_q.gain, op: l_q.b1, arg: l_q.b2};
            l_d.cmd_evt = 1'b1;
          end
          l_d.done = !l_q.ok || !l_q.busy;
        end
        default: begin
          if (pidx == {1'b0, plen}) begin
            l_d.busy = 1'b0;
            l_d.done = 1'b1;
          end
        end
      endcase
    end
  end

  // Sample on the falling edge of the shift clock
  always_ff @(negedge sclk or posedge frame_idle) begin
    if (frame_idle) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // Not cleared by the selects: the master side takes it after the frame
  always_ff @(negedge sclk) begin
    cmd_keep_q <= cmd_keep_d;
  end

  always_comb begin
    t_d.active = 1'b1;
    t_d.dout = out_byte[~l_q.bits];
  end

  // Drive on the rising edge so the host samples a settled bit
  always_ff @(posedge sclk or posedge frame_idle) begin
    if (frame_idle) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  // Data function during a frame, ready function otherwise
  assign serial_out_ready_pin_oe = ~frame_idle;
  assign serial_out_ready_pin_out = (t_q.active && !l_q.done) ? t_q.dout :
    (converter_select_n ? 1'b1 : s_q.ready_n);

  // ---------------- Checks ----------------
  a_ready_start_high: assert property (@(posedge clk) disable iff (reset)
    conv_start |=> conv_ready_n) else $error("ready not high after start");
  a_ready_read_high: assert property (@(posedge clk) disable iff (reset)
    busy_rise && continuous_mode && !conv_start |=> conv_ready_n
  ) else $error("ready not high on read");
  a_lead_pulse: assert property (@(posedge clk) disable iff (reset)
    lead_hit && !conv_start && !conv_stop |=> conv_ready_n [*8]
  ) else $error("lead pulse missing");
  a_fall_deferred: assert property (@(posedge clk) disable iff (reset)
    conv_done && busy_s && !conv_start |=> conv_ready_n && s_q.pending
  ) else $error("ready fell during read");
  a_late_bit_zero: assert property (@(posedge clk) disable iff (reset)
    busy_rise && s_q.lead_seen |=> !s_q.hold.status[STAT_READY_BIT]
  ) else $error("late read reports new");
  a_new_fall: assert property (@(posedge clk) disable iff (reset)
    conv_done && !busy_s && !s_q.pending && !conv_start
    |=> !conv_ready_n && s_q.new_flag
  ) else $error("ready did not fall on new data");
  a_pulse_low_hold: assert property (@(posedge clk) disable iff (reset)
    conv_done && !continuous_mode && !busy_s && !conv_start
    ##1 !conv_start [*2] |-> !conv_ready_n
  ) else $error("pulse mode ready rose");
  a_clip_high: assert property (@(posedge clk) disable iff (reset)
    conv_done && !conv_raw[RAW_W-1] && |conv_raw[RAW_W-2:23]
    |=> conv_result == CODE_POS_MAX
  ) else $error("positive overdrive not clipped");
  a_err_flag_set: assert property (@(posedge clk) disable iff (reset)
    err_edge && !l_q.err_gain |=> converter_crc_error_flag
  ) else $error("converter CRC flag not set");
  a_first_byte_ff: assert property (@(negedge sclk) disable iff (frame_idle)
    l_q.bytes == 4'h0 |-> t_q.dout
  ) else $error("first byte bit not one");
  a_echo_byte: assert property (@(negedge sclk) disable iff (frame_idle)
    l_q.bytes == 4'h1 |-> t_q.dout == l_q.b1[~l_q.bits]
  ) else $error("echo of byte one wrong");
  a_pin_float: assert property (@(posedge clk) disable iff (reset)
    frame_idle |-> !serial_out_ready_pin_oe
  ) else $error("pin driven with both selects high");

  c_conv_cycle: cover property (@(posedge clk) disable iff (reset)
    conv_start ##[1:1000] conv_done);
  c_read_taken: cover property (@(posedge clk) disable iff (reset)
    busy_rise);
  c_deferred: cover property (@(posedge clk) disable iff (reset)
    s_q.pending ##1 !s_q.pending);
  c_crc_error: cover property (@(posedge clk) disable iff (reset)
    err_edge);
endmodule

// ==== bench/acl_host_model.sv ====
// Host model: mode 1 serial master that frames commands and collects replies
`timescale 1ns/1ns
module acl_host_model (
  // Link pins
  output logic sclk,
  output logic converter_select_n,
  output logic gain_stage_select_n,
  output logic serial_in,
  input wire logic pin,
  // Bytes collected from the device
  output logic [7:0] rx_byte,
  output logic rx_toggle
);
  initial begin
    sclk = 1'b0;
    // Selects rise after time zero so the link logic sees a reset edge
    #1;
    converter_select_n = 1'b1;
    gain_stage_select_n = 1'b1;
    serial_in = 1'b0;
    rx_byte = 8'h00;
    rx_toggle = 1'b0;
  end

  // Shift clock runs only inside the frame, with no fixed phase to clk
  task automatic xfer(input logic gain, input logic [71:0] tx,
                      input int nbits);
    logic [7:0] sh;
    sh = 8'h00;
    if (gain) gain_stage_select_n = 1'b0;
    else converter_select_n = 1'b0;
    // Odd lead keeps the shift edges away from the master clock edges
    #53;
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b1;
      serial_in = tx[71 - i];
      #40;
      sclk = 1'b0;
      sh = {sh[6:0], pin};
      if (i % 8 == 7) begin
        rx_byte = sh;
        rx_toggle = ~rx_toggle;
      end
      #40;
    end
    // Stopping early after a bad reply is the caller's choice of nbits
    converter_select_n = 1'b1;
    gain_stage_select_n = 1'b1;
    serial_in = ~serial_in;
    #200;
  endtask
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench for the converter readback and CRC link
`timescale 1ns/1ns
module tb_top;
  import acl_pkg::*;
  typedef struct {int gap; int lead; logic [23:0] res;} acl_note_t;
  logic clk, reset, conv_start, conv_stop, continuous_mode;
  logic [23:0] data_period, exp;
  logic signed [27:0] conv_raw;
  logic status_append_enable, clear_crc_flags, conv_ready_n, cmd_valid;
  logic converter_crc_error_flag, gain_stage_crc_error_flag;
  logic gain_stage_summary_flag, sclk, converter_select_n;
  logic gain_stage_select_n, serial_in, pin_out, pin_oe, pin, pin_last;
  logic [7:0] conversion_status_byte, rx_byte;
  logic [23:0] conv_result;
  logic rx_toggle, rdy_prev;
  logic [31:0] seed, r;
  acl_cmd_t cmd;
  acl_note_t note;
  logic [7:0] byte_q[$];
  acl_cmd_t cmd_q[$];
  acl_note_t rdy_q[$];
  int fails, n_checks, cyc, rise_cyc, fall_cyc;
  logic signed [27:0] raws [4] = '{28'sh0900000, 28'shF600000,
                                    28'sh0000000, 28'sh0000001};

  acl_link #(.RAW_W(28)) dut (.clk(clk), .reset(reset),
    .conv_start(conv_start), .conv_stop(conv_stop),
    .continuous_mode(continuous_mode), .data_period(data_period),
    .conv_raw(conv_raw), .status_append_enable(status_append_enable),
    .clear_crc_flags(clear_crc_flags), .conv_ready_n(conv_ready_n),
    .converter_crc_error_flag(converter_crc_error_flag),
    .gain_stage_crc_error_flag(gain_stage_crc_error_flag),
    .gain_stage_summary_flag(gain_stage_summary_flag),
    .conversion_status_byte(conversion_status_byte),
    .conv_result(conv_result), .cmd_valid(cmd_valid), .cmd(cmd),
    .sclk(sclk), .converter_select_n(converter_select_n),
    .gain_stage_select_n(gain_stage_select_n), .serial_in(serial_in),
    .serial_out_ready_pin_out(pin_out), .serial_out_ready_pin_oe(pin_oe));
  acl_host_model host (.sclk(sclk), .converter_select_n(converter_select_n),
    .gain_stage_select_n(gain_stage_select_n), .serial_in(serial_in),
    .pin(pin), .rx_byte(rx_byte), .rx_toggle(rx_toggle));

  // Released pin has no pull, so show the opposite of the last driven bit
  always @(pin_out or pin_oe) if (pin_oe === 1'b1) pin_last = pin_out;
  assign pin = (pin_oe === 1'b1) ? pin_out : ~pin_last;
  always #20 clk = ~clk;

  function automatic logic [7:0] crc8(input logic [31:0] a, input int n);
    logic [39:0] v;
    v = {a, 8'hFF} | (40'hFFFFFFFFFF >> (n * 8));
    for (int i = 39; i >= 8; i--) if (v[i]) v[i -: 9] ^= CRC_POLY;
    return v[7:0];
  endfunction
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [23:0] clip(input logic signed [27:0] v);
    if (v > 28'sh07FFFFF) return CODE_POS_MAX;
    if (v < -28'sh0800000) return CODE_NEG_MIN;
    return v[23:0];
  endfunction

  task automatic chk_val(input logic [23:0] got, input logic [23:0] want,
                         input string what);
    n_checks++;
    if (got !== want) begin
      fails++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, want);
    end
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic pulse_ctl(input logic stop);
    step(1);
    if (stop) conv_stop = 1'b1;
    else conv_start = 1'b1;
    step(1);
    conv_stop = 1'b0;
    conv_start = 1'b0;
  endtask
  task automatic push_note(input int gap, input int lead, input logic [23:0] v);
    acl_note_t t;
    t.gap = gap;
    t.lead = lead;
    t.res = v;
    rdy_q.push_back(t);
  endtask
  task automatic wait_falls();
    while (rdy_q.size() > 0) @(posedge clk);
    #2;
  endtask
  // One command frame, with the replies it should draw noted in advance
  task automatic frame(input logic gain, input logic [7:0] op,
                       input logic [7:0] arg, input logic bad,
                       input logic [31:0] pay, input int npay);
    logic [7:0] c;
    c = crc8({op, arg, 16'h0000}, 2);
    byte_q.push_back(FILL_BYTE);
    byte_q.push_back(op);
    byte_q.push_back(arg);
    byte_q.push_back(bad ? ~c : c);
    for (int i = 0; i < npay; i++) byte_q.push_back(pay[31 - 8 * i -: 8]);
    if (npay > 0) byte_q.push_back(crc8(pay, npay));
    if (!bad) cmd_q.push_back(acl_cmd_t'{gain, op, arg});
    host.xfer(gain, {op, arg, bad ? c ^ 8'h01 : c, 48'h0},
              32 + (npay > 0 ? 8 * (npay + 1) : 0));
  endtask

  // Skip the model's start-up assignment, which is not a byte
  always @(rx_toggle) if (cyc > 0) begin
    if (byte_q.size() == 0) chk_val(24'h1, 24'h0, "extra byte");
    else chk_val(24'(rx_byte), 24'(byte_q.pop_front()), "byte");
  end
  always @(posedge clk) if (!reset && cmd_valid === 1'b1) begin
    if (cmd_q.size() == 0) chk_val(24'h1, 24'h0, "extra command");
    else chk_val(24'(cmd), 24'(cmd_q.pop_front()), "command");
  end
  always @(converter_select_n or gain_stage_select_n) begin
    #30;
    if (converter_select_n === 1'b1 && gain_stage_select_n === 1'b1)
      chk_val(24'(pin_oe), 24'h0, "pin floats");
    else if (converter_select_n === 1'b0)
      chk_val(24'(pin), 24'(conv_ready_n), "pin ready");
  end
  // Ceiling is several times the expected run of about 5200 cycles
  always @(posedge clk) begin
    cyc++;
    if (!reset && rdy_prev === 1'b0 && conv_ready_n === 1'b1) rise_cyc = cyc;
    if (!reset && rdy_prev === 1'b1 && conv_ready_n === 1'b0) begin
      if (rdy_q.size() == 0) chk_val(24'h1, 24'h0, "extra fall");
      else begin
        note = rdy_q.pop_front();
        if (note.gap > 0)
          chk_val(24'(cyc - fall_cyc), 24'(note.gap), "spacing");
        if (note.lead > 0)
          chk_val(24'(cyc - rise_cyc), 24'(note.lead), "lead");
        chk_val(conv_result, note.res, "result");
      end
      fall_cyc = cyc;
    end
    rdy_prev = conv_ready_n;
    if (cyc > 30000) begin
      chk_val(24'h1, 24'h0, "timeout");
      results();
    end
  end

  initial begin
    {fails, n_checks, cyc, rise_cyc, fall_cyc} = '0;
    {clk, conv_start, conv_stop, clear_crc_flags, pin_last} = '0;
    {reset, rdy_prev, continuous_mode} = 3'h7;
    seed = 32'hE987;
    status_append_enable = 1'b0;
    data_period = 24'h000028;
    conv_raw = 28'sh0000123;
    step(10);
    reset = 1'b0;
    chk_val(24'(conv_ready_n), 24'h1, "reset ready");
    chk_val(24'({converter_crc_error_flag, gain_stage_crc_error_flag,
                 gain_stage_summary_flag}), 24'h0, "reset flags");
    push_note(0, 0, 24'h000123);
    repeat (4) push_note(40, 16, 24'h000123);
    pulse_ctl(1'b0);
    wait_falls();
    pulse_ctl(1'b1);
    r = rnd();
    data_period = 24'h000190;
    conv_raw = r[27:0];
    exp = clip(conv_raw);
    push_note(0, 0, exp);
    pulse_ctl(1'b0);
    wait_falls();
    status_append_enable = 1'b1;
    push_note(400, 0, exp);
    frame(1'b0, OP_READ_DATA, r[7:0], 1'b0, {8'h40, exp}, 4);
    chk_val(24'(conv_ready_n), 24'h1, "ready after read");
    push_note(400, 16, exp);
    wait_falls();
    // Late read: snapshot after the lead point, completion during the read
    step(343);
    conv_raw = 28'sh0000456;
    push_note(0, 0, 24'h000456);
    frame(1'b0, OP_READ_DATA, r[7:0], 1'b0, {8'h00, exp}, 4);
    wait_falls();
    pulse_ctl(1'b1);
    continuous_mode = 1'b0;
    for (int k = 0; k < 5; k++) begin
      r = rnd();
      step(1);
      conv_raw = (k < 4) ? raws[k] : r[27:0];
      exp = clip(conv_raw);
      push_note(0, 0, exp);
      pulse_ctl(1'b0);
      wait_falls();
      step(100);
      chk_val(24'(conv_ready_n), 24'h0, "pulse low");
    end
    frame(1'b0, OP_READ_DATA, r[7:0], 1'b0, {8'h40, exp}, 4);
    step(1);
    status_append_enable = 1'b0;
    frame(1'b0, OP_READ_DATA, r[15:8], 1'b0, {exp, 8'h00}, 3);
    frame(1'b0, 8'h21, r[23:16], 1'b0, 32'h0, 1);
    frame(1'b0, 8'h00, r[7:0], 1'b1, 32'h0, 0);
    chk_val(24'(converter_crc_error_flag), 24'h1, "conv crc flag");
    frame(1'b1, 8'h00, r[15:8], 1'b1, 32'h0, 0);
    chk_val(24'({gain_stage_crc_error_flag, gain_stage_summary_flag}), 24'h3,
            "gain crc flags");
    frame(1'b0, 8'h21, r[23:16], 1'b0, 32'h30000000, 1);
    byte_q.push_back(FILL_BYTE);
    host.xfer(1'b0, {8'h12, 64'h0}, 12);
    frame(1'b1, 8'h00, r[31:24], 1'b0, 32'h0, 0);
    step(1);
    clear_crc_flags = 1'b1;
    step(1);
    clear_crc_flags = 1'b0;
    step(3);
    chk_val(24'(conversion_status_byte), 24'h0, "cleared status");
    step(20);
    chk_val(24'(byte_q.size() + cmd_q.size()), 24'h0, "missing replies");
    results();
  end
endmodule
